// File: bench/osc_model.sv
// free-running oscillator sources feeding the controller
`timescale 1ns/100ps
module osc_model (
  // levels: rc, crystal, watchdog, rtc
  output logic [3:0] osc_lvl_o
);
  // ---------------------------------------------------------------
  // sources run unrelated to clk_i, so the synchronisers are exercised
  // ---------------------------------------------------------------
  initial osc_lvl_o = 4'h0;
  always #42 osc_lvl_o[0] = ~osc_lvl_o[0];
  always #51 osc_lvl_o[1] = ~osc_lvl_o[1];
  always #990 osc_lvl_o[2] = ~osc_lvl_o[2];
  always #1500 osc_lvl_o[3] = ~osc_lvl_o[3];
endmodule

// File: bench/test_clk_pwr_ctrl.sv
// register and power mode tests of the clock and power control
`timescale 1ns/100ps
module test_clk_pwr_ctrl
  import clk_pwr_pkg::*;
;
  // ---------------------------------------------------------------
  // stimulus and checks
  // ---------------------------------------------------------------
  logic clk_i = 1'h0;
  logic arst_n_i = 1'h0;
  logic [7:0] awaddr_i = 8'h00;
  logic [7:0] araddr_i = 8'h00;
  logic awvalid_i = 1'h0, wvalid_i = 1'h0, bready_i = 1'h0;
  logic arvalid_i = 1'h0, rready_i = 1'h0, irq_i = 1'h0;
  logic [31:0] wdata_i = 32'h0, rdata_o, d;
  logic [3:0] wstrb_i = 4'hf, osc_lvl_i;
  logic [7:0] wake_i = 8'h00;
  logic [1:0] bresp_o, rresp_o, pwr_mode_o, r;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, core_halt_o;
  logic irc_en_o, analog_pd_o, flash_standby_o;
  int n_mismatch = 0;
  int num_checks = 0;
  always #5 clk_i = ~clk_i;
  osc_model osc_u (.osc_lvl_o(osc_lvl_i));
  clk_pwr_ctrl #(.LOCK_CYC(20)) dut_u (.clk_i, .arst_n_i, .awaddr_i,
    .awvalid_i, .awready_o, .wdata_i, .wstrb_i, .wvalid_i, .wready_o,
    .bresp_o, .bvalid_o, .bready_i, .araddr_i, .arvalid_i, .arready_o,
    .rdata_o, .rresp_o, .rvalid_o, .rready_i, .osc_lvl_i, .wake_i, .irq_i,
    .irc_en_o, .sysosc_en_o(), .wdosc_en_o(), .brownout_detector_en_o(),
    .analog_pd_o, .flash_standby_o, .flash_pd_o(), .main_clk_o(),
    .core_clk_o(), .periph_clk_o(), .wdt_clk_o(), .usb_clk_o(),
    .async_clk_o(), .clock_observe_pin_o(), .rtc_1hz_o(), .rtc_1khz_o(),
    .pwr_mode_o, .core_halt_o);
  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    awaddr_i <= a;
    wdata_i <= v;
    awvalid_i <= 1'h1;
    wvalid_i <= 1'h1;
    bready_i <= 1'h1;
    fork
      begin
        @(posedge clk_i iff awready_o);
        awvalid_i <= 1'h0;
      end
      begin
        @(posedge clk_i iff wready_o);
        wvalid_i <= 1'h0;
      end
    join
    @(posedge clk_i iff bvalid_o);
    r = bresp_o;
    bready_i <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    araddr_i <= a;
    arvalid_i <= 1'h1;
    rready_i <= 1'h1;
    @(posedge clk_i iff arready_o);
    arvalid_i <= 1'h0;
    @(posedge clk_i iff rvalid_o);
    d = rdata_o;
    r = rresp_o;
    rready_i <= 1'h0;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #300000;
    n_mismatch++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'h1;
    @(posedge clk_i);
    chk("irc_en", 32'h1, irc_en_o);
    rd(OFS_PLL0);
    chk("pll0", 32'h0, d);
    // rc 12 mhz x4 = 48 mhz out, /4 keeps the oscillator at 192 mhz
    wr(OFS_PLL0, 32'h47);
    repeat (60) @(posedge clk_i);
    rd(OFS_PLL0);
    chk("lock", 32'h247, d);
    wr(OFS_MAIN_SEL, 32'h4);
    rd(OFS_MAIN_SEL);
    chk("main_sel", 32'h4, d);
    rd(8'h40);
    chk("unmapped", 32'h2, {30'h0, r});
    wr(OFS_PERIPH_GATE, 32'ha5a5_0f0f);
    rd(OFS_PERIPH_GATE);
    chk("gate", 32'ha5a5_0f0f, d);
    wr(OFS_PWR_MODE, 32'h1);
    repeat (3) @(posedge clk_i);
    chk("halt", 32'h1, core_halt_o);
    irq_i <= 1'h1;
    repeat (8) @(posedge clk_i);
    chk("sleep_exit", 32'h0, pwr_mode_o);
    // crystal is never selected, so no start-up wait is owed
    wr(OFS_WAKE_EN, 32'h1);
    wr(OFS_PWR_MODE, 32'h2);
    repeat (8) @(posedge clk_i);
    chk("deep", 32'h2, pwr_mode_o);
    chk("analog", 32'h1, analog_pd_o);
    chk("flash", 32'h1, flash_standby_o);
    irq_i <= 1'h0;
    wake_i <= 8'h01;
    repeat (8) @(posedge clk_i);
    chk("deep_exit", 32'h0, pwr_mode_o);
    wake_i <= 8'h00;
    wr(OFS_PWR_MODE, 32'h3);
    repeat (4) @(posedge clk_i);
    chk("pdown_rc", 32'h0, irc_en_o);
    summarize();
  end
endmodule

// File: hdl/clk_pwr_ctrl.sv
// clock source selection, pll control, gating and power mode control
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
module clk_pwr_ctrl
  import clk_pwr_pkg::*;
#(
  parameter int unsigned LOCK_CYC = PLL_LOCK_CYC
) (
  // clock and reset
  input logic clk_i,
  input logic arst_n_i,
  // axi4-lite register slave
  input logic [ADDR_W-1:0] awaddr_i,
  input logic awvalid_i,
  output logic awready_o,
  input logic [31:0] wdata_i,
  input logic [3:0] wstrb_i,
  input logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input logic bready_i,
  input logic [ADDR_W-1:0] araddr_i,
  input logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input logic rready_i,
  // oscillator levels: rc, crystal, watchdog, rtc
  input logic [NOSC-1:0] osc_lvl_i,
  // wake requests and pending interrupt
  input logic [NWAKE-1:0] wake_i,
  input logic irq_i,
  // oscillator and analog control
  output logic irc_en_o,
  output logic sysosc_en_o,
  output logic wdosc_en_o,
  output logic brownout_detector_en_o,
  output logic analog_pd_o,
  output logic flash_standby_o,
  output logic flash_pd_o,
  // clocks
  output logic main_clk_o,
  output logic core_clk_o,
  output logic [NPERIPH-1:0] periph_clk_o,
  output logic wdt_clk_o,
  output logic usb_clk_o,
  output logic async_clk_o,
  output logic clock_observe_pin_o,
  output logic rtc_1hz_o,
  output logic rtc_1khz_o,
  // power state
  output logic [1:0] pwr_mode_o,
  output logic core_halt_o
);
  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  logic [NOSC-1:0] osc_s;
  logic [NWAKE-1:0] wake_s;
  logic irq_s;

  assign async_in = {irq_i, wake_i, osc_lvl_i};
  for (genvar k = 0; k < NSYNC; k++) begin : g_sync
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        sync1_q[k] <= 1'b0;
        sync2_q[k] <= 1'b0;
      end else begin
        sync1_q[k] <= async_in[k];
        sync2_q[k] <= sync1_q[k];
      end
    end
  end
  assign osc_s = sync2_q[NOSC-1:0];
  assign wake_s = sync2_q[NOSC+NWAKE-1:NOSC];
  assign irq_s = sync2_q[NSYNC-1];

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  logic aw_rdy_q, w_rdy_q, aw_got_q, w_got_q, bvalid_q, ar_rdy_q;
  logic rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q, rd_data, wmask, wr_data;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic wr_en, wr_hit, rd_hit;

  assign wr_en = aw_got_q && w_got_q && !bvalid_q;
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{w_strb_q[b]}};
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_rdy_q <= 1'b0;
      aw_got_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (awvalid_i && aw_rdy_q) begin
      aw_rdy_q <= 1'b0;
      aw_got_q <= 1'b1;
      aw_addr_q <= awaddr_i;
    end else if (wr_en) begin
      aw_got_q <= 1'b0;
    end else if (!aw_got_q && !bvalid_q) begin
      aw_rdy_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      w_rdy_q <= 1'b0;
      w_got_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (wvalid_i && w_rdy_q) begin
      w_rdy_q <= 1'b0;
      w_got_q <= 1'b1;
      w_data_q <= wdata_i;
      w_strb_q <= wstrb_i;
    end else if (wr_en) begin
      w_got_q <= 1'b0;
    end else if (!w_got_q && !bvalid_q) begin
      w_rdy_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_en) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bready_i) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ar_rdy_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (arvalid_i && ar_rdy_q) begin
      ar_rdy_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_data;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && rready_i) begin
      rvalid_q <= 1'b0;
    end else if (!rvalid_q) begin
      ar_rdy_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  logic [2:0] main_sel_q, obs_sel_q;
  logic [CTL_W-1:0] ctl_q;
  logic [PLL_CFG_W-1:0] pll_cfg_q [NPLL];
  logic [NPERIPH-1:0] gate_q;
  logic [NWAKE-1:0] wake_en_q;
  logic [ADDR_W-1:0] pll_ofs [NPLL];
  pwr_mode_e pm_q;
  logic [NPLL-1:0] pll_out, pll_lock;

  assign pll_ofs[0] = OFS_PLL0;
  assign pll_ofs[1] = OFS_PLL1;
  assign pll_ofs[2] = OFS_PLL2;

  function automatic logic [31:0] wdata_or_old(logic [ADDR_W-1:0] a);
    logic [31:0] v;
    v = '0;
    case (a)
      OFS_MAIN_SEL: v[2:0] = main_sel_q;
      OFS_OSC_CTRL: v[CTL_W-1:0] = ctl_q;
      OFS_PLL0: v[PLL_CFG_W-1:0] = pll_cfg_q[0];
      OFS_PLL1: v[PLL_CFG_W-1:0] = pll_cfg_q[1];
      OFS_PLL2: v[PLL_CFG_W-1:0] = pll_cfg_q[2];
      OFS_PERIPH_GATE: v = gate_q;
      OFS_OBS_SEL: v[2:0] = obs_sel_q;
      OFS_PWR_MODE: v[1:0] = pm_q;
      OFS_WAKE_EN: v[NWAKE-1:0] = wake_en_q;
      default: v = '0;
    endcase
    return v;
  endfunction

  assign wr_data = (wdata_or_old(aw_addr_q) & ~wmask) | (w_data_q & wmask);

  always_comb begin
    rd_data = wdata_or_old(araddr_i);
    for (int i = 0; i < NPLL; i++) begin
      if (araddr_i == pll_ofs[i]) begin
        rd_data[PLL_LOCK_BIT] = pll_lock[i];
      end
    end
    rd_hit = araddr_i <= OFS_WAKE_EN && araddr_i[1:0] == 2'h0;
    wr_hit = aw_addr_q <= OFS_WAKE_EN && aw_addr_q[1:0] == 2'h0;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      main_sel_q <= SRC_IRC;
      ctl_q <= CTL_RST;
      obs_sel_q <= SRC_IRC;
      gate_q <= GATE_RST;
      wake_en_q <= '0;
    end else if (wr_en) begin
      case (aw_addr_q)
        OFS_MAIN_SEL: main_sel_q <= wr_data[2:0];
        OFS_OSC_CTRL: ctl_q <= wr_data[CTL_W-1:0];
        OFS_PERIPH_GATE: gate_q <= wr_data;
        OFS_OBS_SEL: obs_sel_q <= wr_data[2:0];
        OFS_WAKE_EN: wake_en_q <= wr_data[NWAKE-1:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // power mode sequencer
  // ---------------------------------------------------------------
  logic running, deep, pdown, wake_hit;

  assign wake_hit = |(wake_s & wake_en_q);
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pm_q <= PM_ACTIVE;
    end else begin
      case (pm_q)
        PM_ACTIVE: begin
          if (wr_en && aw_addr_q == OFS_PWR_MODE) begin
            pm_q <= pwr_mode_e'(wr_data[1:0]);
          end
        end
        PM_SLEEP: begin
          if (irq_s || wake_hit) begin
            pm_q <= PM_ACTIVE;
          end
        end
        PM_DEEP, PM_PDOWN: begin
          if (wake_hit) begin
            pm_q <= PM_ACTIVE;
          end
        end
        default: pm_q <= PM_ACTIVE;
      endcase
    end
  end
  assign running = pm_q == PM_ACTIVE || pm_q == PM_SLEEP;
  assign deep = pm_q == PM_DEEP;
  assign pdown = pm_q == PM_PDOWN;

  // ---------------------------------------------------------------
  // plls: main, usb, async
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NPLL; i++) begin : g_pll
    pll_if pif();
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        pll_cfg_q[i] <= '0;
      end else if (wr_en && aw_addr_q == pll_ofs[i]) begin
        pll_cfg_q[i] <= wr_data[PLL_CFG_W-1:0];
      end
    end
    // deep sleep and power-down stop every pll; sleep keeps them running
    assign pif.enable = pll_cfg_q[i][PLL_EN_BIT] && running;
    assign pif.mult_m1 = pll_cfg_q[i][PLL_M_LSB +: MULT_W];
    assign pif.div_sel = pll_cfg_q[i][PLL_P_LSB +: DIV_W];
    assign pif.ref_lvl = pll_cfg_q[i][PLL_REF_BIT] ? osc_s[OSC_SYS]
                                                   : osc_s[OSC_IRC];
    assign pll_out[i] = pif.clk_out;
    assign pll_lock[i] = pif.locked;
    pll_core #(.LOCK_CYC(LOCK_CYC)) u_pll (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .bus(pif.core)
    );
  end

  // ---------------------------------------------------------------
  // clock selection and gating
  // ---------------------------------------------------------------
  // codes 0-3 pick an oscillator, 4-6 a pll and 7 the main clock
  logic [7:0] obs_vec;
  logic [4:0] main_vec;
  logic main_lvl, wdt_sel_wd, wd_on;
  logic [RTC_DIV_W-1:0] rtc_cnt_q;
  logic rtc_q;

  assign obs_vec = {main_lvl, pll_out, osc_s};
  // separate vector keeps main_lvl out of its own fan-in
  assign main_vec = {pll_out[PLL_MAIN], osc_s};
  // unused codes fall back to the rc oscillator
  assign main_lvl = main_sel_q <= SRC_PLL ? main_vec[main_sel_q]
                                          : osc_s[OSC_IRC];
  assign wdt_sel_wd = ctl_q[CTL_WDT_SEL];
  assign wd_on = ctl_q[CTL_WD_EN] && (running
                 || (deep && ctl_q[CTL_WD_KEEP]) || (pdown && wdt_sel_wd));

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      main_clk_o <= 1'b0;
      core_clk_o <= 1'b0;
      periph_clk_o <= '0;
      usb_clk_o <= 1'b0;
      async_clk_o <= 1'b0;
      clock_observe_pin_o <= 1'b0;
    end else begin
      main_clk_o <= main_lvl && running;
      core_clk_o <= main_lvl && pm_q == PM_ACTIVE;
      periph_clk_o <= gate_q & {NPERIPH{main_lvl && running}};
      usb_clk_o <= pll_out[PLL_USB] && running;
      async_clk_o <= pll_out[PLL_ASYNC] && running;
      clock_observe_pin_o <= obs_vec[obs_sel_q];
    end
  end

  // rc keeps running in deep sleep but reaches only the watchdog and the observe pin
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wdt_clk_o <= 1'b0;
      irc_en_o <= 1'b1;
      sysosc_en_o <= 1'b0;
      wdosc_en_o <= 1'b0;
      brownout_detector_en_o <= 1'b0;
      analog_pd_o <= 1'b0;
      flash_standby_o <= 1'b0;
      flash_pd_o <= 1'b0;
    end else begin
      wdt_clk_o <= wdt_sel_wd ? (osc_s[OSC_WD] && wd_on)
                              : (osc_s[OSC_IRC] && !pdown);
      irc_en_o <= !pdown;
      sysosc_en_o <= ctl_q[CTL_SYS_EN] && running;
      wdosc_en_o <= wd_on;
      brownout_detector_en_o <= ctl_q[CTL_BOD_EN];
      analog_pd_o <= !running;
      flash_standby_o <= deep;
      flash_pd_o <= pdown;
    end
  end

  // rtc divider: 32768 / 32 and 32768 / 32768
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rtc_q <= 1'b0;
      rtc_cnt_q <= '0;
      rtc_1khz_o <= 1'b0;
      rtc_1hz_o <= 1'b0;
      pwr_mode_o <= 2'h0;
      core_halt_o <= 1'b0;
    end else begin
      rtc_q <= osc_s[OSC_RTC];
      if (osc_s[OSC_RTC] && !rtc_q) begin
        rtc_cnt_q <= rtc_cnt_q + 15'h0001;
      end
      rtc_1khz_o <= rtc_cnt_q[RTC_1K_BIT];
      rtc_1hz_o <= rtc_cnt_q[RTC_1HZ_BIT];
      pwr_mode_o <= pm_q;
      core_halt_o <= pm_q != PM_ACTIVE;
    end
  end

  assign awready_o = aw_rdy_q;
  assign wready_o = w_rdy_q;
  assign bvalid_o = bvalid_q;
  assign bresp_o = bresp_q;
  assign arready_o = ar_rdy_q;
  assign rvalid_o = rvalid_q;
  assign rdata_o = rdata_q;
  assign rresp_o = rresp_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  main_hold_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    main_sel_q != $past(main_sel_q) |->
      $past(wr_en && aw_addr_q == OFS_MAIN_SEL))
    else $error("main source changed without a write");
  sleep_core_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    pm_q == PM_SLEEP ##1 pm_q == PM_SLEEP |->
      !core_clk_o && main_clk_o == $past(main_lvl))
    else $error("sleep clock gating wrong");
  deep_off_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    deep |=> !sysosc_en_o && periph_clk_o == '0 && analog_pd_o
             && flash_standby_o && irc_en_o)
    else $error("deep sleep leaves a source running");
  pdown_off_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    pdown |=> !irc_en_o && flash_pd_o && wdosc_en_o == $past(
      ctl_q[CTL_WD_EN] && wdt_sel_wd))
    else $error("power-down leaves a source running");
  wake_exit_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !running && wake_hit |=> pm_q == PM_ACTIVE ##1 !analog_pd_o)
    else $error("enabled wake did not leave low power");
  sleep_irq_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    pm_q == PM_SLEEP && irq_s |=> pm_q == PM_ACTIVE ##1 !core_halt_o)
    else $error("interrupt did not end sleep");
  gate_off_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !gate_q[0] |=> !periph_clk_o[0])
    else $error("gated peripheral clock still runs");
  resp_hold_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    bvalid_q && !bready_i |=> bvalid_q && $stable(bresp_q))
    else $error("write response dropped early");
endmodule

// File: hdl/clk_pwr_pkg.sv
// constants, field layouts and types of the clock and power mode control
package clk_pwr_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned PLL_LOCK_US = 100;
  localparam int unsigned PLL_LOCK_CYC = PLL_LOCK_US * CLK_MHZ;
  localparam int unsigned LOCK_W = 24;
  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int unsigned NPLL = 3;
  localparam int unsigned NOSC = 4;
  localparam int unsigned NPERIPH = 32;
  localparam int unsigned NWAKE = 8;
  localparam int unsigned NSYNC = NOSC + NWAKE + 1;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned MULT_W = 5;
  localparam int unsigned DIV_W = 2;
  localparam int unsigned ACC_W = 7;
  localparam int unsigned RTC_DIV_W = 15;
  localparam int unsigned RTC_1K_BIT = 4;
  localparam int unsigned RTC_1HZ_BIT = 14;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_MAIN_SEL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_OSC_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PLL0 = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PLL1 = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_PLL2 = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_PERIPH_GATE = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_OBS_SEL = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_PWR_MODE = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_WAKE_EN = 8'h20;
  // ---------------------------------------------------------------
  // fields and encodings
  // ---------------------------------------------------------------
  localparam logic [2:0] SRC_IRC = 3'h0;
  localparam logic [2:0] SRC_PLL = 3'h4;
  localparam int unsigned OSC_IRC = 0;
  localparam int unsigned OSC_SYS = 1;
  localparam int unsigned OSC_WD = 2;
  localparam int unsigned OSC_RTC = 3;
  localparam int unsigned CTL_SYS_EN = 0;
  localparam int unsigned CTL_WD_EN = 1;
  localparam int unsigned CTL_WDT_SEL = 2;
  localparam int unsigned CTL_WD_KEEP = 3;
  localparam int unsigned CTL_BOD_EN = 4;
  localparam int unsigned CTL_W = 5;
  localparam int unsigned PLL_EN_BIT = 0;
  localparam int unsigned PLL_M_LSB = 1;
  localparam int unsigned PLL_P_LSB = 6;
  localparam int unsigned PLL_REF_BIT = 8;
  localparam int unsigned PLL_LOCK_BIT = 9;
  localparam int unsigned PLL_CFG_W = 9;
  localparam int unsigned PLL_MAIN = 0;
  localparam int unsigned PLL_USB = 1;
  localparam int unsigned PLL_ASYNC = 2;
  localparam logic [NPERIPH-1:0] GATE_RST = 32'h0000_0000;
  localparam logic [CTL_W-1:0] CTL_RST = 5'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {PM_ACTIVE, PM_SLEEP, PM_DEEP, PM_PDOWN}
    pwr_mode_e;
endpackage

// File: hdl/pll_core.sv
// behavioural multiply and post-divide pll with lock timer and bypass
`timescale 1ns/100ps
module pll_core
  import clk_pwr_pkg::*;
#(
  parameter int unsigned LOCK_CYC = PLL_LOCK_CYC
) (
  // clock and reset
  input logic clk_i,
  input logic arst_n_i,
  // controller side
  pll_if.core bus
);
  logic ref_q;
  logic out_q;
  logic lock_q;
  logic [LOCK_W-1:0] cnt_q;
  logic [MULT_W+DIV_W-1:0] cfg_q;
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] half;
  logic [ACC_W-1:0] sum;
  logic [ACC_W-1:0] rest;
  logic ref_rise;
  logic cfg_chg;

  // ---------------------------------------------------------------
  // ratio arithmetic
  // ---------------------------------------------------------------
  // field is m-1, so every code is a legal multiplier
  assign sum = acc_q + {2'h0, bus.mult_m1} + 7'h01;
  // half the post divide ratio: 1,2,4,8 for /2,/4,/8,/16
  assign half = 7'h01 << bus.div_sel;
  assign rest = sum - half;
  assign ref_rise = bus.ref_lvl & ~ref_q;
  assign cfg_chg = cfg_q != {bus.mult_m1, bus.div_sel};

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ref_q <= 1'b0;
      cfg_q <= '0;
    end else begin
      ref_q <= bus.ref_lvl;
      cfg_q <= {bus.mult_m1, bus.div_sel};
    end
  end

  // ---------------------------------------------------------------
  // lock timer
  // ---------------------------------------------------------------
  // a new ratio restarts the settling time
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= '0;
      lock_q <= 1'b0;
    end else if (!bus.enable || cfg_chg) begin
      cnt_q <= '0;
      lock_q <= 1'b0;
    end else if (cnt_q == LOCK_W'(LOCK_CYC - 1)) begin
      lock_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 24'h000001;
    end
  end

  // ---------------------------------------------------------------
  // output
  // ---------------------------------------------------------------
  // toggling keeps 50 % duty; at most one toggle per reference edge,
  // so high ratios saturate at half the reference rate
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_q <= 1'b0;
      acc_q <= '0;
    end else if (!bus.enable) begin
      out_q <= bus.ref_lvl;
      acc_q <= '0;
    end else if (!lock_q) begin
      out_q <= 1'b0;
      acc_q <= '0;
    end else if (ref_rise && sum >= half) begin
      out_q <= ~out_q;
      acc_q <= (rest >= half) ? '0 : rest;
    end else if (ref_rise) begin
      acc_q <= sum;
    end
  end

  assign bus.clk_out = out_q;
  assign bus.locked = lock_q;

  bypass_path_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !bus.enable |=> !lock_q && out_q == $past(bus.ref_lvl))
    else $error("disabled pll is not bypassed");
  lock_wait_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(bus.enable) |-> !lock_q [*8])
    else $error("pll locked too early");
  lock_count_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(lock_q) |-> $past(cnt_q) == LOCK_W'(LOCK_CYC - 1))
    else $error("lock flag set before settling time");
endmodule

// File: hdl/pll_if.sv
// control and result signals between the controller and one pll
`timescale 1ns/100ps
interface pll_if;
  logic enable;
  logic [4:0] mult_m1;
  logic [1:0] div_sel;
  logic ref_lvl;
  logic clk_out;
  logic locked;
  modport ctrl(output enable, mult_m1, div_sel, ref_lvl,
               input clk_out, locked);
  modport core(input enable, mult_m1, div_sel, ref_lvl,
               output clk_out, locked);
endinterface
